// file: src/vdc_vco_divider_regs.v
`timescale 1ns/1ns
`include "vdc_defines.vh"

module vdc_vco_divider_regs (
  // Clock and reset
  input  wire                    clk_sys,
  input  wire                    rst_n,
  // Register access from the serial control port
  input  wire                    regWrite,
  input  wire [`VDC_ADDR_W-1:0]  regAddr,
  input  wire [7:0]              regWdata,
  output reg  [7:0]              regRdata,
  // Status from the output synthesizer loop
  input  wire                    outputSynthLoopLocked,
  // Controls toward the analog and distribution sections
  output reg                     distSyncHold,
  output reg                     vcoMidscale,
  output reg                     calStart,
  output reg                     calReset,
  output reg                     vcoDivPowerDown,
  output reg  [3:0]              vcoDivRatio,
  output reg  [1:0]              secondPoleResistor,
  output reg  [2:0]              zeroResistor,
  output reg  [2:0]              firstPoleCap
);

  // Sync release states
  localparam [0:0] SYNC_HOLD = 1'h0;
  localparam [0:0] SYNC_FREE = 1'h1;

  // Calibration sequencer states
  localparam [1:0] CAL_IDLE  = 2'h0;
  localparam [1:0] CAL_KICK  = 2'h1;
  localparam [1:0] CAL_RUN   = 2'h2;

  // Stored register images and the read mux value
  reg  [7:0] oscCtrl;
  reg  [7:0] divCtrl;
  reg  [7:0] loopFilt;
  reg  [7:0] next_rdata;

  // Sequencer state and next values
  reg        syncState;
  reg        next_syncState;
  reg  [1:0] calState;
  reg  [1:0] next_calState;

  // Address decode; only the three mapped offsets answer
  wire       selOsc     = (regAddr == `VDC_ADDR_OSC_CTRL);
  wire       selDiv     = (regAddr == `VDC_ADDR_DIV_CTRL);
  wire       selLoop    = (regAddr == `VDC_ADDR_LOOP_FILT);

  // Write strobes, one per register
  wire       wrOsc      = regWrite & selOsc;
  wire       wrDiv      = regWrite & selDiv;
  wire       wrLoop     = regWrite & selLoop;

  // Oscillator control bits
  wire       forceRel   = oscCtrl[`VDC_OSC_FORCE_REL];
  wire       midscale   = oscCtrl[`VDC_OSC_MIDSCALE];
  wire       calLevel   = oscCtrl[`VDC_OSC_CAL];
  wire       releaseReq = forceRel | outputSynthLoopLocked;

  // Divider control bits
  wire       divPdn     = divCtrl[`VDC_DIV_PDN];
  wire [2:0] divCode    = divCtrl[`VDC_DIV_CODE_HI:`VDC_DIV_CODE_LO];

  // Oscillator control; bit 3 never stored, so a stray write cannot reach the analog side
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oscCtrl <= `VDC_RST_OSC;
    end else if (wrOsc) begin
      oscCtrl <= regWdata & `VDC_OSC_WMASK;
    end
  end

  // Divider control; reserved upper nibble reads zero
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divCtrl <= `VDC_RST_DIV;
    end else if (wrDiv) begin
      divCtrl <= regWdata & `VDC_DIV_WMASK;
    end
  end

  // Loop filter codes; every bit is writable
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loopFilt <= `VDC_RST_LF;
    end else if (wrLoop) begin
      loopFilt <= regWdata;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    case (regAddr)
      `VDC_ADDR_OSC_CTRL:  next_rdata = oscCtrl;
      `VDC_ADDR_DIV_CTRL:  next_rdata = divCtrl;
      `VDC_ADDR_LOOP_FILT: next_rdata = loopFilt;
      default:             next_rdata = 8'h00;
    endcase
  end

  // Read data from a flop; the address of one cycle answers on the next
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= `VDC_RST_RDATA;
    end else begin
      regRdata <= next_rdata;
    end
  end

  // Sync release next state; follows lock live unless release is forced
  always @* begin
    case (syncState)
      SYNC_HOLD: begin
        if (releaseReq) begin
          next_syncState = SYNC_FREE;
        end else begin
          next_syncState = SYNC_HOLD;
        end
      end
      SYNC_FREE: begin
        if (releaseReq) begin
          next_syncState = SYNC_FREE;
        end else begin
          next_syncState = SYNC_HOLD;                           // Lock lost, back in hold
        end
      end
      default: begin
        next_syncState = SYNC_HOLD;
      end
    endcase
  end

  // Hold output tracks the next state, one edge behind lock or a forced release
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncState    <= SYNC_HOLD;
      distSyncHold <= `VDC_RST_SYNC_HOLD;
    end else begin
      syncState    <= next_syncState;
      distSyncHold <= (next_syncState == SYNC_HOLD);
    end
  end

  // Calibration sequencer; the bit is a level, so only IDLE can start a run
  always @* begin
    case (calState)
      CAL_IDLE: begin
        if (calLevel) begin
          next_calState = CAL_KICK;
        end else begin
          next_calState = CAL_IDLE;
        end
      end
      CAL_KICK: begin
        if (calLevel) begin
          next_calState = CAL_RUN;
        end else begin
          next_calState = CAL_IDLE;
        end
      end
      CAL_RUN: begin
        if (calLevel) begin
          next_calState = CAL_RUN;                              // Not self-clearing
        end else begin
          next_calState = CAL_IDLE;
        end
      end
      default: begin
        next_calState = CAL_IDLE;
      end
    endcase
  end

  // One start pulse per 0-to-1 change; rewriting 1 while running gives none
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      calState <= CAL_IDLE;
      calStart <= 1'h0;
      calReset <= `VDC_RST_CAL_RESET;
    end else begin
      calState <= next_calState;
      calStart <= (next_calState == CAL_KICK);
      calReset <= (next_calState == CAL_IDLE);
    end
  end

  // Oscillator tuning and divider controls
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vcoMidscale     <= 1'h0;
      vcoDivPowerDown <= 1'h0;
      vcoDivRatio     <= `VDC_DIV_BASE;
    end else begin
      vcoMidscale     <= midscale;
      vcoDivPowerDown <= divPdn;
      // One ratio for every channel: code plus the base of four
      vcoDivRatio     <= `VDC_DIV_BASE + {1'h0, divCode};
    end
  end

  // Loop filter codes pass through; the analog side decodes the values
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      secondPoleResistor <= 2'h0;
      zeroResistor       <= 3'h0;
      firstPoleCap       <= 3'h0;
    end else begin
      secondPoleResistor <= loopFilt[`VDC_LF_RPOLE_HI:`VDC_LF_RPOLE_LO];
      zeroResistor       <= loopFilt[`VDC_LF_ZERO_RESISTOR_HI:`VDC_LF_ZERO_RESISTOR_LO];
      firstPoleCap       <= loopFilt[`VDC_LF_CPOLE_HI:`VDC_LF_CPOLE_LO];
    end
  end

endmodule // vdc_vco_divider_regs

// file: common/vdc_defines.vh
`ifndef VDC_DEFINES_VH
`define VDC_DEFINES_VH

// Register addresses on the serial control port (10-bit address space)
`define VDC_ADDR_W          10
`define VDC_ADDR_OSC_CTRL   10'h0F3
`define VDC_ADDR_DIV_CTRL   10'h0F4
`define VDC_ADDR_LOOP_FILT  10'h0F5

// Oscillator control fields
`define VDC_OSC_FORCE_REL   4
`define VDC_OSC_KEEP_ZERO   3
`define VDC_OSC_MIDSCALE    2
`define VDC_OSC_CAL         1
`define VDC_OSC_WMASK       8'h16

// Divider control fields
`define VDC_DIV_PDN         3
`define VDC_DIV_CODE_HI     2
`define VDC_DIV_CODE_LO     0
`define VDC_DIV_WMASK       8'h0F
`define VDC_DIV_BASE        4'h4

// Loop filter fields
`define VDC_LF_RPOLE_HI     7
`define VDC_LF_RPOLE_LO     6
`define VDC_LF_ZERO_RESISTOR_HI     5
`define VDC_LF_ZERO_RESISTOR_LO     3
`define VDC_LF_CPOLE_HI     2
`define VDC_LF_CPOLE_LO     0

// Reset values
`define VDC_RST_OSC         8'h00
`define VDC_RST_DIV         8'h00
`define VDC_RST_LF          8'h00
`define VDC_RST_RDATA       8'h00
`define VDC_RST_SYNC_HOLD   1'h1
`define VDC_RST_CAL_RESET   1'h1

`endif

// file: tb/vdc_regs_chk.sv
`timescale 1ns/1ns
module vdc_regs_chk (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       regWrite,
  input wire [9:0] regAddr,
  input wire [7:0] regWdata,
  input wire       outputSynthLoopLocked,
  input wire       distSyncHold,
  input wire       vcoMidscale,
  input wire       calStart,
  input wire       calReset,
  input wire       vcoDivPowerDown,
  input wire [3:0] vcoDivRatio
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Writes seen at the oscillator and divider registers
  wire wOsc = regWrite && regAddr == 10'h0F3;
  wire wDiv = regWrite && regAddr == 10'h0F4;
  chk_hold_unlock: assert property (
    (wOsc && !regWdata[4] && !outputSynthLoopLocked) ##1 !outputSynthLoopLocked
    |=> distSyncHold) else $error("no hold");
  chk_lock_rel: assert property (
    $past(outputSynthLoopLocked) |-> !distSyncHold) else $error("held in lock");
  chk_force_rel: assert property (
    wOsc && regWdata[4] |-> ##2 !distSyncHold) else $error("no force");
  chk_mid_sel: assert property (
    wOsc |-> ##2 vcoMidscale == $past(regWdata[2], 2)) else $error("midscale");
  chk_cal_reset: assert property (
    wOsc && !regWdata[1] |-> ##2 calReset && !calStart) else $error("cal reset");
  // A clear written right behind the start may raise calReset in the next cycle
  chk_cal_pulse: assert property (
    calStart |-> !calReset ##1
    (!calStart && calReset == ($past(wOsc, 2) && !$past(regWdata[1], 2))))
    else $error("cal pulse");
  chk_div_pdn: assert property (
    wDiv |-> ##2 vcoDivPowerDown == $past(regWdata[3], 2)) else $error("pdn");
  chk_div_ratio: assert property (
    wDiv |-> ##2 vcoDivRatio == {1'b0, $past(regWdata[2:0], 2)} + 4'h4)
    else $error("ratio");
  cover property (calStart);
  cover property (wOsc && regWdata[4]);
  cover property (wDiv && regWdata[2:0] == 3'h7);
endmodule // vdc_regs_chk

// file: tb/vdc_vco_divider_regs_tb.sv
`timescale 1ns/1ns
module vdc_vco_divider_regs_tb;
  reg        clk, rst_n, we, lk;
  reg  [9:0] a;
  reg  [7:0] d;
  wire [7:0] q;
  wire       hold, mid, cs, cr, pdn;
  wire [3:0] rat;
  wire [1:0] rp;
  wire [2:0] rz, cp;
  integer    error_cnt = 0, n_checks = 0, i;
  vdc_vco_divider_regs dut_u (.clk_sys(clk), .rst_n(rst_n), .regWrite(we), .regAddr(a),
    .regWdata(d), .regRdata(q), .outputSynthLoopLocked(lk), .distSyncHold(hold),
    .vcoMidscale(mid), .calStart(cs), .calReset(cr), .vcoDivPowerDown(pdn), .vcoDivRatio(rat),
    .secondPoleResistor(rp), .zeroResistor(rz), .firstPoleCap(cp));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task chk(input [7:0] s, input [7:0] e); begin
    n_checks = n_checks + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  end endtask
  // Write, then let outputs and read-back settle two edges
  task wr(input [9:0] ad, input [7:0] dt); begin
    @(negedge clk); we = 1; a = ad; d = dt;
    @(negedge clk); we = 0;
    repeat (2) @(negedge clk);
  end endtask
  task final_report; begin
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  task t_osc; begin
    wr(10'h0F3, 8'h17); chk(q, 8'h16); chk(mid, 1);
    chk(hold, 0); chk(cr, 0);
    wr(10'h0F3, 8'h00); chk(hold, 1); chk(cr, 1); chk(mid, 0);
    @(negedge clk); lk = 1; repeat (2) @(negedge clk); chk(hold, 0);
    lk = 0; repeat (2) @(negedge clk); chk(hold, 1);
  end endtask
  // Calibration: 0 then 1 gives one start pulse; a repeated 1 gives none
  task t_cal; begin
    wr(10'h0F3, 8'h00); chk(cr, 1); chk(cs, 0);
    @(negedge clk); we = 1; a = 10'h0F3; d = 8'h02;
    @(negedge clk); we = 0; chk(cs, 0);
    @(negedge clk); chk(cs, 1); chk(cr, 0);
    @(negedge clk); chk(cs, 0); chk(cr, 0);
    @(negedge clk); we = 1; d = 8'h02;
    @(negedge clk); we = 0;
    @(negedge clk); chk(cs, 0); chk(cr, 0);
  end endtask
  task t_div; begin
    for (i = 0; i < 8; i = i + 1) begin
      wr(10'h0F4, {4'hF, i[0], i[2:0]}); chk(rat, i[7:0] + 8'h4); chk(pdn, i[0]);
    end
    chk(q, 8'h0F);
  end endtask
  // Loop filter fields and an unmapped address
  task t_map; begin
    wr(10'h0F5, 8'hA5); chk({rp, rz, cp}, 8'hA5); chk(q, 8'hA5);
    wr(10'h100, 8'hFF); chk(q, 8'h00);
    chk({rp, rz, cp}, 8'hA5);
  end endtask
  initial begin
    we = 0; lk = 0; a = 10'h000; d = 8'h00; rst_n = 0;
    repeat (8) @(negedge clk);
    rst_n = 1;
    chk(hold, 1); chk(rat, 4); chk(cr, 1);
    t_osc; t_cal; t_div; t_map;
    final_report;
  end
  // Hang guard
  initial begin
    #3000 error_cnt = error_cnt + 1;
    final_report;
  end
endmodule // vdc_vco_divider_regs_tb
bind vdc_vco_divider_regs vdc_regs_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
  .outputSynthLoopLocked(outputSynthLoopLocked), .distSyncHold(distSyncHold),
  .vcoMidscale(vcoMidscale), .calStart(calStart), .calReset(calReset),
  .vcoDivPowerDown(vcoDivPowerDown), .vcoDivRatio(vcoDivRatio));
